// ==== src/tvt_pkg.sv ====
package tvt_pkg;
  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [5:0] OFS_RELOAD_HIGH = 6'h2c;
  localparam logic [5:0] OFS_RELOAD_LOW = 6'h2d;
  localparam logic [5:0] OFS_COUNT_HIGH = 6'h2e;
  localparam logic [5:0] OFS_COUNT_LOW = 6'h2f;
  localparam logic [5:0] OFS_PAGE = 6'h30;
  localparam logic [5:0] OFS_TEST_SEL_ONE = 6'h31;
  localparam logic [5:0] OFS_TEST_SEL_TWO = 6'h32;
  localparam logic [5:0] OFS_TIMER_CTRL = 6'h3e;
  localparam logic [5:0] OFS_TIMER_STATUS = 6'h3f;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int PAGE_ENABLE_BIT = 7;
  localparam int PAGE_NUM_LSB = 0;
  localparam int SM_CLK_LSB = 4;
  localparam int SM_CLK_TO_D1_BIT = 3;
  localparam int PROBE_BIT_LSB = 0;
  localparam int REORDER_BIT = 7;
  localparam int PRBS9_BIT = 6;
  localparam int PRBS15_BIT = 5;
  localparam int PROBE_BUS_LSB = 0;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_STOP_BIT = 1;
  localparam int CTRL_AUTO_BIT = 2;
  localparam int CTRL_SEND_BIT = 3;
  localparam int STAT_RUN_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  // ----------------------------------------
  // Reset values and seeds
  // ----------------------------------------
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [8:0] PRBS9_SEED = 9'h1ff;
  localparam logic [14:0] PRBS15_SEED = 15'h7fff;
  // ----------------------------------------
  // Clock source encodings
  // ----------------------------------------
  localparam logic [1:0] SM_CLK_OFF = 2'h0;
  localparam logic [1:0] SM_CLK_OSC = 2'h1;
  localparam logic [1:0] SM_CLK_UART = 2'h2;
  localparam logic [1:0] SM_CLK_RF = 2'h3;
endpackage : tvt_pkg

// ==== src/tvt_regs.sv ====
// Summary of operation
// - Reload value in two bytes, 2Ch/2Dh
// - Counter loads reload on start and at zero with auto-reload
// - Count readable at 2Eh/2Fh, read-only
// - Page enable: page supplies address bits 5:4
// - Page disabled: latch gives whole address
// - Page field bits 1:0 at 30h
// - Page bits 6:2 read zero
// - Clock source select: off, osc, uart, rf
// - Bit 3 routes secure clock to D1
// - Bits 2:0 pick probe bit for output
// - Bits 4:0 select observed test bus
// - Reorder maps bus D4,D3,D2,D6,D5,D0,D1
// - Bit 6 starts PRBS9 generator
// - Bit 5 starts PRBS15 generator
// - PRBS sent only after transmit command
// - Writable registers reset to 00h
// - Without auto-reload stop at zero, flag
`timescale 1ns/1ps
`default_nettype none
module tvt_regs #(
  parameter int BUS_COUNT = 32
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic [5:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Timer tick from prescaler
  input wire logic timer_tick,
  // Secure module clock sources (async)
  input wire logic clk_osc_in,
  input wire logic clk_uart_in,
  input wire logic clk_rf_in,
  // Internal test buses
  input wire logic [BUS_COUNT*8-1:0] probe_buses,
  // Outputs
  output logic [5:0] eff_addr,
  output logic signal_output_pin,
  output logic [6:0] data_pin_out,
  output logic [6:0] data_pin_oe,
  output logic secure_clock_out,
  output logic prbs_tx_bit,
  output logic prbs_tx_valid,
  output logic countdown_done_flag
);
  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [7:0] reload_upper_byte;
  logic [7:0] reload_lower_byte;
  logic page_override_enable;
  logic [1:0] page_number;
  logic [7:0] test_sel_one;
  logic [7:0] test_sel_two;
  logic auto_reload_enable;
  logic [15:0] count;
  logic running;
  logic sending;
  logic [8:0] prbs9;
  logic [14:0] prbs15;
  logic [2:0] osc_sync, uart_sync, rf_sync;
  logic [15:0] reload_value;

  // ----------------------------------------
  // Address forming
  // ----------------------------------------
  wire logic [5:0] next_eff_addr = page_override_enable ? {page_number, addr[3:0]} : addr;
  wire logic wr_hit = wr;
  wire logic wr_ctrl = wr_hit && next_eff_addr == tvt_pkg::OFS_TIMER_CTRL;
  wire logic start_evt = wr_ctrl && wdata[tvt_pkg::CTRL_START_BIT];
  wire logic stop_evt = wr_ctrl && wdata[tvt_pkg::CTRL_STOP_BIT];
  wire logic send_evt = wr_ctrl && wdata[tvt_pkg::CTRL_SEND_BIT];

  function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  assign reload_value = {reload_upper_byte, reload_lower_byte};

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reload_upper_byte <= tvt_pkg::REG_RESET;
      reload_lower_byte <= tvt_pkg::REG_RESET;
      page_override_enable <= 1'b0;
      page_number <= 2'h0;
      test_sel_one <= tvt_pkg::REG_RESET;
      test_sel_two <= tvt_pkg::REG_RESET;
      auto_reload_enable <= 1'b0;
    end else if (wr) begin
      if (hit(next_eff_addr, tvt_pkg::OFS_RELOAD_HIGH)) reload_upper_byte <= wdata;
      if (hit(next_eff_addr, tvt_pkg::OFS_RELOAD_LOW)) reload_lower_byte <= wdata;
      if (hit(next_eff_addr, tvt_pkg::OFS_PAGE)) begin
        page_override_enable <= wdata[tvt_pkg::PAGE_ENABLE_BIT];
        page_number <= wdata[tvt_pkg::PAGE_NUM_LSB +: 2];
      end
      if (hit(next_eff_addr, tvt_pkg::OFS_TEST_SEL_ONE)) test_sel_one <= wdata;
      if (hit(next_eff_addr, tvt_pkg::OFS_TEST_SEL_TWO)) test_sel_two <= wdata;
      if (wr_ctrl) auto_reload_enable <= wdata[tvt_pkg::CTRL_AUTO_BIT];
    end
  end

  // ----------------------------------------
  // Timer counter
  // ----------------------------------------
  wire logic at_zero = (count == 16'h0000);
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 16'h0000;
      running <= 1'b0;
      countdown_done_flag <= 1'b0;
    end else begin
      if (start_evt) begin
        count <= reload_value;
        running <= 1'b1;
      end else if (stop_evt) begin
        running <= 1'b0;
      end else if (running && timer_tick) begin
        if (at_zero) begin
          if (auto_reload_enable) count <= reload_value;
          else running <= 1'b0;
        end else begin
          count <= count - 16'h0001;
        end
      end
      // Set wins over clear by ordering
      if (wr_ctrl && wdata[tvt_pkg::STAT_DONE_BIT + 4]) countdown_done_flag <= 1'b0;
      if (running && timer_tick && at_zero && !start_evt) countdown_done_flag <= 1'b1;
    end
  end

  // ----------------------------------------
  // Read mux
  // ----------------------------------------
  wire logic [7:0] page_read = {page_override_enable, 5'h00, page_number};
  wire logic [7:0] status_read = {6'h00, countdown_done_flag, running};
  logic [7:0] next_rdata;
  always_comb begin
    case (next_eff_addr)
      tvt_pkg::OFS_RELOAD_HIGH: next_rdata = reload_upper_byte;
      tvt_pkg::OFS_RELOAD_LOW: next_rdata = reload_lower_byte;
      tvt_pkg::OFS_COUNT_HIGH: next_rdata = count[15:8];
      tvt_pkg::OFS_COUNT_LOW: next_rdata = count[7:0];
      tvt_pkg::OFS_PAGE: next_rdata = page_read;
      tvt_pkg::OFS_TEST_SEL_ONE: next_rdata = test_sel_one;
      tvt_pkg::OFS_TEST_SEL_TWO: next_rdata = test_sel_two;
      tvt_pkg::OFS_TIMER_CTRL: next_rdata = {5'h00, auto_reload_enable, 2'h0};
      tvt_pkg::OFS_TIMER_STATUS: next_rdata = status_read;
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= 8'h00;
      eff_addr <= 6'h00;
    end else begin
      rdata <= rd ? next_rdata : 8'h00;
      eff_addr <= next_eff_addr;
    end
  end

  // ----------------------------------------
  // Secure module clock
  // ----------------------------------------
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      osc_sync <= 3'h0;
      uart_sync <= 3'h0;
      rf_sync <= 3'h0;
    end else begin
      osc_sync <= {osc_sync[1:0], clk_osc_in};
      uart_sync <= {uart_sync[1:0], clk_uart_in};
      rf_sync <= {rf_sync[1:0], clk_rf_in};
    end
  end
  wire logic [1:0] secure_module_clock_source = test_sel_one[tvt_pkg::SM_CLK_LSB +: 2];
  wire logic secure_clock_to_data_pin = test_sel_one[tvt_pkg::SM_CLK_TO_D1_BIT];
  logic next_sm_clk;
  always_comb begin
    case (secure_module_clock_source)
      tvt_pkg::SM_CLK_OFF: next_sm_clk = 1'b0;
      tvt_pkg::SM_CLK_OSC: next_sm_clk = osc_sync[1];
      tvt_pkg::SM_CLK_UART: next_sm_clk = uart_sync[1];
      tvt_pkg::SM_CLK_RF: next_sm_clk = rf_sync[1];
      default: next_sm_clk = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Test bus probing
  // ----------------------------------------
  wire logic [2:0] probe_bit_select = test_sel_one[tvt_pkg::PROBE_BIT_LSB +: 3];
  wire logic [4:0] probe_bus_select = test_sel_two[tvt_pkg::PROBE_BUS_LSB +: 5];
  wire logic probe_port_reorder = test_sel_two[tvt_pkg::REORDER_BIT];
  wire logic [7:0] probe_bus = probe_buses[probe_bus_select * 8 +: 8];
  // Bus bits 6..0 land on D4,D3,D2,D6,D5,D0,D1
  wire logic [6:0] reordered = {probe_bus[3], probe_bus[2], probe_bus[6], probe_bus[5],
                                probe_bus[4], probe_bus[0], probe_bus[1]};
  logic [6:0] next_pin_out;
  logic [6:0] next_pin_oe;
  always_comb begin
    next_pin_out = probe_port_reorder ? reordered : 7'h00;
    next_pin_oe = probe_port_reorder ? 7'h7f : 7'h00;
    if (secure_clock_to_data_pin) begin
      next_pin_out[1] = next_sm_clk;
      next_pin_oe[1] = 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      signal_output_pin <= 1'b0;
      data_pin_out <= 7'h00;
      data_pin_oe <= 7'h00;
      secure_clock_out <= 1'b0;
    end else begin
      signal_output_pin <= probe_bus[probe_bit_select];
      data_pin_out <= next_pin_out;
      data_pin_oe <= next_pin_oe;
      secure_clock_out <= next_sm_clk;
    end
  end

  // ----------------------------------------
  // PRBS generators
  // ----------------------------------------
  wire logic prbs9_en = test_sel_two[tvt_pkg::PRBS9_BIT];
  wire logic prbs15_en = test_sel_two[tvt_pkg::PRBS15_BIT];
  wire logic prbs_any = prbs9_en || prbs15_en;
  wire logic fb9 = prbs9[8] ^ prbs9[4];
  wire logic fb15 = prbs15[14] ^ prbs15[13];
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      prbs9 <= tvt_pkg::PRBS9_SEED;
      prbs15 <= tvt_pkg::PRBS15_SEED;
      sending <= 1'b0;
      prbs_tx_bit <= 1'b0;
      prbs_tx_valid <= 1'b0;
    end else begin
      if (!prbs9_en) prbs9 <= tvt_pkg::PRBS9_SEED;
      else if (sending) prbs9 <= {prbs9[7:0], fb9};
      if (!prbs15_en) prbs15 <= tvt_pkg::PRBS15_SEED;
      else if (sending) prbs15 <= {prbs15[13:0], fb15};
      if (!prbs_any) sending <= 1'b0;
      else if (send_evt) sending <= 1'b1;
      prbs_tx_valid <= sending && prbs_any;
      prbs_tx_bit <= prbs9_en ? fb9 : fb15;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence start_seq;
    start_evt;
  endsequence
  load_on_start_a: assert property (@(posedge mclk) disable iff (!rst_n)
    start_seq |=> count == $past(reload_value)) else $error("count not loaded on start");
  hold_on_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr && !start_evt && !timer_tick && !stop_evt) |=> $stable(count)) else $error("count moved on write");
  count_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd && next_eff_addr == tvt_pkg::OFS_COUNT_LOW) |=> rdata == $past(count[7:0])) else $error("count read bad");
  page_addr_a: assert property (@(posedge mclk) disable iff (!rst_n)
    page_override_enable |=> eff_addr[5:4] == $past(page_number)) else $error("page bits not used");
  latch_addr_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !page_override_enable |=> eff_addr == $past(addr)) else $error("latch address not used");
  page_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd && next_eff_addr == tvt_pkg::OFS_PAGE) |=> rdata[6:2] == 5'h00) else $error("reserved page bits set");
  clk_off_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (secure_module_clock_source == tvt_pkg::SM_CLK_OFF) |=> !secure_clock_out) else $error("clock not off");
  d1_drive_a: assert property (@(posedge mclk) disable iff (!rst_n)
    secure_clock_to_data_pin |=> data_pin_oe[1]) else $error("D1 not driven");
  no_send_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (!sending && !send_evt) |=> !sending) else $error("PRBS sent without command");
  stop_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (running && timer_tick && at_zero && !auto_reload_enable && !start_evt) |=> !running && countdown_done_flag)
    else $error("timer did not stop at zero");

  // ----------------------------------------
  // Register and output checks
  // ----------------------------------------
  // Tick at zero with auto-reload enabled and no other timer command
  sequence reload_tick_seq;
    running && timer_tick && at_zero && auto_reload_enable && !start_evt && !stop_evt;
  endsequence
  auto_reload_a: assert property (@(posedge mclk) disable iff (!rst_n)
    reload_tick_seq |=> running && count == $past(reload_value))
    else $error("timer did not reload at zero");
  reload_high_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr && hit(next_eff_addr, tvt_pkg::OFS_RELOAD_HIGH)) |=> reload_upper_byte == $past(wdata))
    else $error("reload upper byte not written");
  reload_low_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr && hit(next_eff_addr, tvt_pkg::OFS_RELOAD_LOW)) |=> reload_lower_byte == $past(wdata))
    else $error("reload lower byte not written");
  count_high_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd && next_eff_addr == tvt_pkg::OFS_COUNT_HIGH) |=> rdata == $past(count[15:8]))
    else $error("count upper read bad");
  rdata_idle_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !rd |=> rdata == 8'h00)
    else $error("read data stood too long");
  page_write_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr && hit(next_eff_addr, tvt_pkg::OFS_PAGE)) |=> page_number == $past(wdata[1:0]))
    else $error("page field not written");
  page_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (rd && next_eff_addr == tvt_pkg::OFS_PAGE) |=> rdata[1:0] == $past(page_number))
    else $error("page field read bad");
  clk_osc_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (secure_module_clock_source == tvt_pkg::SM_CLK_OSC) |=> secure_clock_out == $past(osc_sync[1]))
    else $error("oscillator clock not selected");
  clk_uart_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (secure_module_clock_source == tvt_pkg::SM_CLK_UART) |=> secure_clock_out == $past(uart_sync[1]))
    else $error("uart clock not selected");
  clk_rf_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (secure_module_clock_source == tvt_pkg::SM_CLK_RF) |=> secure_clock_out == $past(rf_sync[1]))
    else $error("field clock not selected");
  d1_value_a: assert property (@(posedge mclk) disable iff (!rst_n)
    secure_clock_to_data_pin |=> data_pin_out[1] == secure_clock_out)
    else $error("D1 does not carry secure clock");
  probe_bit_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rst_n |=> signal_output_pin == $past(probe_bus[probe_bit_select]))
    else $error("probe bit not routed");
  reorder_oe_a: assert property (@(posedge mclk) disable iff (!rst_n)
    probe_port_reorder |=> data_pin_oe == 7'h7f)
    else $error("port not driven in reorder");
  no_drive_a: assert property (@(posedge mclk) disable iff (!rst_n)
    (!probe_port_reorder && !secure_clock_to_data_pin) |=> data_pin_oe == 7'h00)
    else $error("port driven while unused");
  prbs9_seed_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !prbs9_en |=> prbs9 == tvt_pkg::PRBS9_SEED)
    else $error("short sequence not seeded");
  prbs15_seed_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !prbs15_en |=> prbs15 == tvt_pkg::PRBS15_SEED)
    else $error("long sequence not seeded");
  valid_en_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !prbs_any |=> !prbs_tx_valid)
    else $error("sequence valid while disabled");
  prbs_live_a: assert property (@(posedge mclk) disable iff (!rst_n)
    rst_n |-> prbs9 != 9'h000 && prbs15 != 15'h0000)
    else $error("sequence state stuck at zero");
endmodule : tvt_regs
`default_nettype wire

// ==== sim/tvt_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module tvt_host (
  // Clock
  input wire logic mclk,
  // Register port
  output logic [5:0] addr,
  output logic [7:0] wdata,
  output logic wr,
  output logic rd,
  input wire logic [7:0] rdata
);
  initial begin
    addr = 6'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
  end
  // ----------------------------------------
  // Bus cycles
  // ----------------------------------------
  // Released write data shows its inverse so stale values never pass
  task automatic put(input logic [5:0] a, input logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    wdata <= ~v;
  endtask : put
  task automatic get(input logic [5:0] a, output logic [7:0] v);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : get
endmodule : tvt_host
`default_nettype wire

// ==== sim/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic mclk, rst_n, wr, rd, timer_tick, clk_osc_in, clk_uart_in, clk_rf_in;
  logic [5:0] addr, eff_addr;
  logic [7:0] wdata, rdata, d, v, b;
  logic [255:0] probe_buses;
  logic [6:0] data_pin_out, data_pin_oe;
  logic [3:0] lv;
  logic signal_output_pin, secure_clock_out, prbs_tx_bit, prbs_tx_valid, countdown_done_flag;
  int bad_count, checked, cycles, n, k, ln, tp;
  logic [15:0] rl;
  logic q[$];
  logic [5:0] ra [7] = '{6'h2c, 6'h2d, 6'h30, 6'h31, 6'h32, 6'h2e, 6'h2f};
  tvt_host host (.mclk(mclk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  tvt_regs #(.BUS_COUNT(32)) dut (.mclk(mclk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .timer_tick(timer_tick), .clk_osc_in(clk_osc_in), .clk_uart_in(clk_uart_in),
    .clk_rf_in(clk_rf_in), .probe_buses(probe_buses), .eff_addr(eff_addr),
    .signal_output_pin(signal_output_pin), .data_pin_out(data_pin_out), .data_pin_oe(data_pin_oe),
    .secure_clock_out(secure_clock_out), .prbs_tx_bit(prbs_tx_bit), .prbs_tx_valid(prbs_tx_valid),
    .countdown_done_flag(countdown_done_flag));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic end_sim;
    if (bad_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : end_sim
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic rchk(input logic [5:0] a, input logic [15:0] exp);
    host.get(a, d);
    check({8'h00, d}, exp);
  endtask : rchk
  task automatic tick(input int t);
    repeat (t) begin
      @(posedge mclk);
      timer_tick <= 1'b1;
      @(posedge mclk);
      timer_tick <= 1'b0;
    end
    #1;
  endtask : tick
  always @(posedge mclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      end_sim();
    end
  end
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(32'h276f));
    {rst_n, timer_tick, clk_osc_in, clk_uart_in, clk_rf_in} = 5'h00;
    bad_count = 0;
    checked = 0;
    cycles = 0;
    for (int i = 0; i < 8; i++) probe_buses[32*i+:32] = $urandom;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    foreach (ra[i]) rchk(ra[i], 16'h0000);
    for (int i = 0; i < 5; i++) begin
      v = $urandom;
      v[7] = (ra[i] == 6'h30) ? 1'b0 : v[7];
      host.put(ra[i], v);
      rchk(ra[i], (ra[i] == 6'h30) ? {8'h00, v & 8'h03} : {8'h00, v});
    end
    host.put(6'h2e, 8'hff);
    rchk(6'h2e, 16'h0000);
    // Timer model: start loads reload, each tick counts down
    rl = $urandom | 16'h0100;
    host.put(6'h2c, rl[15:8]);
    host.put(6'h2d, rl[7:0]);
    host.put(6'h3e, 8'h01);
    tick(2);
    host.put(6'h2c, ~rl[15:8]);
    rchk(6'h2e, (rl - 16'h0002) >> 8);
    rchk(6'h2f, rl[7:0] - 8'h02);
    host.put(6'h2c, 8'h00);
    host.put(6'h2d, 8'h03);
    host.put(6'h3e, 8'h01);
    tick(3);
    check(countdown_done_flag, 1'b0);
    rchk(6'h2f, 16'h0000);
    tick(1);
    check(countdown_done_flag, 1'b1);
    host.put(6'h2d, 8'h02);
    host.put(6'h3e, 8'h25);
    rchk(6'h3f, 16'h0001);
    tick(3);
    rchk(6'h2f, 16'h0002);
    // Page override on and off
    host.put(6'h30, 8'h83);
    host.put(6'h02, 8'h1f);
    rchk(6'h22, 16'h001f);
    check(eff_addr, 6'h32);
    host.put(6'h00, 8'h00);
    rchk(6'h22, 16'h0000);
    check(eff_addr, 6'h22);
    // Probe bit routing and port reorder
    for (int i = 0; i < 6; i++) begin
      n = $urandom_range(31);
      k = $urandom_range(7);
      b = probe_buses[8*n+:8];
      host.put(6'h31, k[7:0]);
      host.put(6'h32, {i[0], 2'b00, n[4:0]});
      repeat (3) @(posedge mclk);
      #1;
      check(signal_output_pin, b[k]);
      check(data_pin_oe, i[0] ? 16'h007f : 16'h0000);
      if (i[0]) check(data_pin_out, {b[3], b[2], b[6], b[5], b[4], b[0], b[1]});
    end
    // Secure clock source select; no parallel host here, so D1 is free
    for (int s = 0; s < 4; s++) begin
      lv = {3'($urandom_range(7)), 1'b0};
      clk_osc_in <= lv[1];
      clk_uart_in <= lv[2];
      clk_rf_in <= lv[3];
      host.put(6'h31, {2'b00, s[1:0], 4'h8});
      repeat (6) @(posedge mclk);
      #1;
      check(secure_clock_out, lv[s]);
      check(data_pin_out[1], lv[s]);
      check(data_pin_oe[1], 1'b1);
    end
    // Both sequence modes, checked against their recurrences
    host.put(6'h31, 8'h00);
    for (int m = 0; m < 2; m++) begin
      ln = m ? 15 : 9;
      tp = m ? 14 : 5;
      q.delete();
      host.put(6'h32, m ? 8'h20 : 8'h40);
      repeat (4) @(posedge mclk);
      #1;
      check(prbs_tx_valid, 1'b0);
      host.put(6'h3e, 8'h08);
      for (int c = 0; c < 60 && q.size() < 45; c++) begin
        @(posedge mclk);
        #1;
        if (prbs_tx_valid === 1'b1) q.push_back(prbs_tx_bit);
      end
      check(q.size(), 45);
      for (int i = ln; i < q.size(); i++) check(q[i], q[i-tp] ^ q[i-ln]);
      check(q.or(), 1'b1);
      host.put(6'h32, 8'h00);
      host.put(6'h3e, 8'h02);
    end
    end_sim();
  end
endmodule : tb
`default_nettype wire
